// ==== apb_drv.sv ====
// apb master model standing in for the decoder and register file side
`timescale 1ns/1ps
`default_nettype none
module apb_drv (
  // clock
  input wire logic clk_i,
  // apb master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h0;
    pwdata_o = 32'h0;
  end

  // one transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines must not keep looking valid
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== cpu_alu_branch_execute.sv ====
// execute stage: alu, multiplier, skips, jumps and branches behind apb
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_branch_execute
  import exec_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // core state
  output logic [15:0] PC_O,
  output logic [7:0] FLAGS_O,
  output logic BUSY_O
);

  function automatic logic [7:0] byte_flags(input logic [7:0] r, input logic c,
                                            input logic v, input logic h);
    logic [7:0] f;
    f = FLAGS_RESET;
    f[FL_C] = c;
    f[FL_Z] = (r == BYTE_ZERO);
    f[FL_N] = r[BYTE_MSB];
    f[FL_V] = v;
    f[FL_S] = r[BYTE_MSB] ^ v;
    f[FL_H] = h;
    return f;
  endfunction

  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] zptr;
  logic [15:0] stack;
  logic [12:0] cmd_last;
  result_s result;
  state_e state;
  logic [CNT_W-1:0] cnt;
  logic [3:0] cyc_last;
  logic skip_last;

  // bus decode
  wire setup = PSEL_I & ~PENABLE_I;
  wire access = PSEL_I & PENABLE_I & PREADY_O;
  wire wr = access & PWRITE_I;
  wire sel_cmd = PADDR_I == OFS_CMD;
  wire sel_opa = PADDR_I == OFS_OPA;
  wire sel_opb = PADDR_I == OFS_OPB;
  wire sel_pc = PADDR_I == OFS_PC;
  wire sel_zptr = PADDR_I == OFS_ZPTR;
  wire sel_stack = PADDR_I == OFS_STACK;
  wire sel_flags = PADDR_I == OFS_FLAGS;
  wire sel_result = PADDR_I == OFS_RESULT;
  wire sel_stat = PADDR_I == OFS_STAT;
  wire mapped = sel_cmd | sel_opa | sel_opb | sel_pc | sel_zptr | sel_stack |
                sel_flags | sel_result | sel_stat;
  wire busy = state == ST_BUSY;
  wire refuse = ~mapped | (sel_cmd & PWRITE_I & busy);
  wire start = wr & sel_cmd & ~PSLVERR_O;
  wire cmd_s cmd = cmd_s'(PWDATA_I[$bits(cmd_s)-1:0]);

  wire [31:0] rd_data =
    sel_cmd ? {19'h0_0000, cmd_last} :
    sel_opa ? {16'h0000, opa} :
    sel_opb ? {16'h0000, opb} :
    sel_pc ? {16'h0000, PC_O} :
    sel_zptr ? {16'h0000, zptr} :
    sel_stack ? {16'h0000, stack} :
    sel_flags ? {24'h00_0000, FLAGS_O} :
    sel_result ? {12'h000, result} :
    sel_stat ? {26'h000_0000, skip_last, cyc_last, busy} : 32'h0000_0000;

  // operands
  wire [7:0] a = opa[7:0];
  wire [7:0] b = opb[7:0];
  wire carry = FLAGS_O[FL_C];
  wire is_neg = cmd.op == OP_TWOS_INVERSE;
  wire borrow_op = cmd.op == OP_DIFFERENCE_WITH_BORROW | cmd.op == OP_COMPARE_REGS_BORROW;
  wire add_ci = (cmd.op == OP_SUM_CARRY) & carry;
  wire sub_ci = borrow_op & carry;

  // byte adder, results wrap modulo 256
  // byte wrap and flags
  wire [8:0] add9 = {1'b0, a} + {1'b0, b} + {8'h00, add_ci};
  wire [7:0] ar = add9[7:0];
  wire add_h = a[NIB_MSB] & b[NIB_MSB] | b[NIB_MSB] & ~ar[NIB_MSB] | ~ar[NIB_MSB] & a[NIB_MSB];
  wire add_v = a[BYTE_MSB] & b[BYTE_MSB] & ~ar[BYTE_MSB] | ~a[BYTE_MSB] & ~b[BYTE_MSB] & ar[BYTE_MSB];
  // twos inverse as zero minus value
  wire [7:0] sx = is_neg ? BYTE_ZERO : a;
  wire [7:0] sy = is_neg ? a : b;
  wire [8:0] sub9 = {1'b0, sx} - {1'b0, sy} - {8'h00, sub_ci};
  wire [7:0] sr = sub9[7:0];
  wire sub_h = ~sx[NIB_MSB] & sy[NIB_MSB] | sy[NIB_MSB] & sr[NIB_MSB] | sr[NIB_MSB] & ~sx[NIB_MSB];
  wire sub_v = sx[BYTE_MSB] & ~sy[BYTE_MSB] & ~sr[BYTE_MSB] | ~sx[BYTE_MSB] & sy[BYTE_MSB] & sr[BYTE_MSB];

  // word unit, results wrap modulo 65536
  wire [15:0] wk = {10'h000, opb[WK_W-1:0]};
  wire [15:0] wadd = opa + wk;
  wire [15:0] wsub = opa - wk;

  // multiplier
  wire [15:0] prod_u = 16'(a * b);
  wire [15:0] prod_s = 16'($signed(a) * $signed(b));
  wire [15:0] prod_m = 16'($signed({a[BYTE_MSB], a}) * $signed({1'b0, b}));

  // program counter targets and tests
  wire [15:0] pc_next = PC_O + PC_STEP;
  wire [15:0] pc_rel = PC_O + opb + PC_STEP;
  wire [15:0] pc_skip = PC_O + (cmd.next_long ? SKIP_LONG : SKIP_SHORT);
  wire bitv = opa[cmd.bit_sel];
  wire flagv = FLAGS_O[cmd.flag_sel];
  wire sgn_lt = FLAGS_O[FL_N] ^ FLAGS_O[FL_V];

  logic [15:0] res;
  logic [7:0] fl;
  logic [7:0] fmask;
  logic [15:0] next_pc;
  logic [3:0] cyc;
  logic we_lo;
  logic we_hi;
  logic push;
  logic pop;
  logic skip;
  logic take;
  logic [7:0] r8;
  logic [15:0] pr;

  always_comb
  begin
    res = opa;
    fl = FLAGS_O;
    fmask = FLAGS_RESET;
    next_pc = pc_next;
    cyc = CYC_ONE;
    we_lo = 1'b0;
    we_hi = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    skip = 1'b0;
    take = 1'b0;
    r8 = BYTE_ZERO;
    pr = prod_u;
    case (cmd.op)
      // byte add and add with carry
      OP_SUM, OP_SUM_CARRY:
      begin
        res = {opa[15:8], ar};
        fl = byte_flags(ar, add9[8], add_v, add_h);
        fmask = M_ARITH;
        we_lo = 1'b1;
      end
      OP_DIFFERENCE, OP_DIFFERENCE_WITH_BORROW, OP_TWOS_INVERSE,
      OP_COMPARE_REGS, OP_COMPARE_REGS_BORROW:
      begin
        res = {opa[15:8], sr};
        fl = byte_flags(sr, sub9[8], sub_v, sub_h);
        if (borrow_op)
          fl[FL_Z] = fl[FL_Z] & FLAGS_O[FL_Z];
        fmask = M_ARITH;
        we_lo = cmd.op != OP_COMPARE_REGS & cmd.op != OP_COMPARE_REGS_BORROW;
      end
      // logic ops keep carry and half carry
      OP_MASK, OP_MERGE, OP_EXCLUSIVE_MERGE, OP_BITS_FORCE_LOW,
      OP_ZERO_MINUS_CHECK, OP_REGISTER_ZEROING:
      begin
        case (cmd.op)
          OP_MASK: r8 = a & b;
          OP_MERGE: r8 = a | b;
          OP_EXCLUSIVE_MERGE: r8 = a ^ b;
          OP_BITS_FORCE_LOW: r8 = a & (BYTE_ONES - b);
          OP_ZERO_MINUS_CHECK: r8 = a & a;
          default: r8 = a ^ a;
        endcase
        res = {opa[15:8], r8};
        fl = byte_flags(r8, 1'b0, 1'b0, 1'b0);
        fmask = M_LOGIC;
        we_lo = 1'b1;
      end
      OP_ONES_INVERSE:
      begin
        r8 = BYTE_ONES - a;
        res = {opa[15:8], r8};
        fl = byte_flags(r8, 1'b1, 1'b0, 1'b0);
        fmask = M_ONES;
        we_lo = 1'b1;
      end
      // plus and minus one keep carry
      OP_PLUS_ONE, OP_MINUS_ONE:
      begin
        r8 = (cmd.op == OP_PLUS_ONE) ? a + BYTE_ONE : a - BYTE_ONE;
        res = {opa[15:8], r8};
        fl = byte_flags(r8, 1'b0, r8 == ((cmd.op == OP_PLUS_ONE) ? INC_OVF : DEC_OVF), 1'b0);
        fmask = M_LOGIC;
        we_lo = 1'b1;
      end
      OP_REGISTER_ALL_ONES:
      begin
        res = {opa[15:8], BYTE_ONES};
        we_lo = 1'b1;
      end
      OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE:
      begin
        res = (cmd.op == OP_WORD_IMMEDIATE_SUM) ? wadd : wsub;
        fl[FL_Z] = res == WORD_ZERO;
        fl[FL_N] = res[WORD_MSB];
        if (cmd.op == OP_WORD_IMMEDIATE_SUM)
        begin
          fl[FL_C] = ~res[WORD_MSB] & opa[WORD_MSB];
          fl[FL_V] = ~opa[WORD_MSB] & res[WORD_MSB];
        end
        else
        begin
          fl[FL_C] = res[WORD_MSB] & ~opa[WORD_MSB];
          fl[FL_V] = opa[WORD_MSB] & ~res[WORD_MSB];
        end
        fl[FL_S] = fl[FL_N] ^ fl[FL_V];
        fmask = M_WORD;
        {we_hi, we_lo} = 2'h3;
        cyc = CYC_TWO;
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED:
      begin
        if (cmd.op == OP_SIGNED_PRODUCT | cmd.op == OP_FRACTION_PRODUCT_SIGNED)
          pr = prod_s;
        else if (cmd.op == OP_MIXED_SIGN_PRODUCT | cmd.op == OP_FRACTION_PRODUCT_MIXED)
          pr = prod_m;
        fl[FL_C] = pr[WORD_MSB];
        res = (cmd.op >= OP_FRACTION_PRODUCT_UNSIGNED) ? {pr[14:0], 1'b0} : pr;
        fl[FL_Z] = res == WORD_ZERO;
        fmask = M_MUL;
        {we_hi, we_lo} = 2'h3;
        cyc = CYC_TWO;
      end
      OP_RELATIVE_GOTO, OP_POINTER_GOTO:
      begin
        next_pc = (cmd.op == OP_RELATIVE_GOTO) ? pc_rel : zptr;
        cyc = CYC_TWO;
      end
      OP_ABSOLUTE_GOTO:
      begin
        next_pc = opb;
        cyc = CYC_THREE;
      end
      OP_RELATIVE_ROUTINE_ENTRY, OP_POINTER_ROUTINE_ENTRY:
      begin
        next_pc = (cmd.op == OP_RELATIVE_ROUTINE_ENTRY) ? pc_rel : zptr;
        res = pc_next;
        push = 1'b1;
        cyc = CYC_THREE;
      end
      OP_DIRECT_ROUTINE_ENTRY:
      begin
        next_pc = opb;
        res = PC_O + CALL_STEP;
        push = 1'b1;
        cyc = CYC_FOUR;
      end
      OP_ROUTINE_EXIT, OP_IRQ_EXIT:
      begin
        next_pc = stack;
        pop = 1'b1;
        fl[FL_I] = 1'b1;
        fmask = (cmd.op == OP_IRQ_EXIT) ? M_IRQ : FLAGS_RESET;
        cyc = CYC_FOUR;
      end
      OP_EQUAL_SKIP, OP_REG_BIT_LOW_SKIP, OP_REG_BIT_HIGH_SKIP,
      OP_IO_BIT_LOW_SKIP, OP_IO_BIT_HIGH_SKIP:
      begin
        if (cmd.op == OP_EQUAL_SKIP)
          skip = a == b;
        else if (cmd.op == OP_REG_BIT_LOW_SKIP | cmd.op == OP_IO_BIT_LOW_SKIP)
          skip = ~bitv;
        else
          skip = bitv;
        if (skip)
        begin
          next_pc = pc_skip;
          cyc = cmd.next_long ? CYC_THREE : CYC_TWO;
        end
      end
      // signed branches on N xor V
      // carry and zero selected by flag index
      // half carry and sign share the timing
      OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
      OP_BRANCH_SIGNED_AT_LEAST, OP_BRANCH_SIGNED_BELOW:
      begin
        case (cmd.op)
          OP_BRANCH_FLAG_HIGH: take = flagv;
          OP_BRANCH_FLAG_LOW: take = ~flagv;
          OP_BRANCH_SIGNED_AT_LEAST: take = ~sgn_lt;
          default: take = sgn_lt;
        endcase
        if (take)
        begin
          next_pc = pc_rel;
          cyc = CYC_TWO;
        end
      end
      default:
      begin
        next_pc = pc_next;
      end
    endcase
  end

  wire [7:0] next_flags = start ? (FLAGS_O & ~fmask) | (fl & fmask) :
                          (wr & sel_flags) ? PWDATA_I[7:0] : FLAGS_O;
  wire [15:0] next_pc_reg = start ? next_pc : (wr & sel_pc) ? PWDATA_I[15:0] : PC_O;
  wire long_op = cyc != CYC_ONE;
  wire last = cnt == CNT_W'(1);
  wire state_e next_state = (start & long_op) ? ST_BUSY : (busy & last) ? ST_IDLE : state;
  wire [CNT_W-1:0] next_cnt = start ? CNT_W'(cyc - CYC_ONE) : busy ? cnt - CNT_W'(1) : cnt;

  // bus answer: ready in the access phase
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end
    else
    begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & refuse;
      PRDATA_O <= (setup & ~PWRITE_I) ? rd_data : PRDATA_O;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      opa <= WORD_ZERO;
      opb <= WORD_ZERO;
      zptr <= WORD_ZERO;
      stack <= WORD_ZERO;
    end
    else
    begin
      opa <= (wr & sel_opa) ? PWDATA_I[15:0] : opa;
      opb <= (wr & sel_opb) ? PWDATA_I[15:0] : opb;
      zptr <= (wr & sel_zptr) ? PWDATA_I[15:0] : zptr;
      stack <= (wr & sel_stack) ? PWDATA_I[15:0] : stack;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PC_O <= PC_RESET;
      FLAGS_O <= FLAGS_RESET;
      BUSY_O <= 1'b0;
      state <= ST_IDLE;
      cnt <= '0;
      result <= '0;
      cmd_last <= '0;
      cyc_last <= '0;
      skip_last <= 1'b0;
    end
    else
    begin
      PC_O <= next_pc_reg;
      FLAGS_O <= next_flags;
      BUSY_O <= next_state == ST_BUSY;
      state <= next_state;
      cnt <= next_cnt;
      result <= start ? {push, pop, we_hi, we_lo, res} : result;
      cmd_last <= start ? cmd : cmd_last;
      cyc_last <= start ? cyc : cyc_last;
      skip_last <= start ? skip : skip_last;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_add_sum: assert property (start && cmd.op == OP_SUM |=> result.value[7:0] ==
    8'($past(opa[7:0]) + $past(opb[7:0])) && result.we_lo) else $error("sum wrong");
  a_logic_keeps: assert property (start && cmd.op == OP_MASK |=>
    FLAGS_O[FL_C] == $past(FLAGS_O[FL_C]) && !FLAGS_O[FL_V]) else $error("logic flags");
  a_cmp_nowrite: assert property (start && cmd.op == OP_COMPARE_REGS |=>
    !result.we_lo && !result.we_hi) else $error("compare wrote");
  a_word_busy: assert property (start && cmd.op == OP_WORD_IMMEDIATE_SUM |=>
    BUSY_O ##1 !BUSY_O) else $error("word op not two cycles");
  a_mul_pair: assert property (start && cmd.op == OP_UNSIGNED_PRODUCT |=>
    result.value == 16'($past(opa[7:0]) * $past(opb[7:0])) && result.we_hi) else $error("mul");
  a_call_cycles: assert property (start && cmd.op == OP_DIRECT_ROUTINE_ENTRY |=>
    BUSY_O [*3] ##1 !BUSY_O) else $error("call not four cycles");
  a_branch_take: assert property (start && cmd.op == OP_BRANCH_FLAG_HIGH && flagv |=>
    PC_O == 16'($past(PC_O) + $past(opb) + PC_STEP) && BUSY_O) else $error("branch pc");
  a_branch_skip: assert property (start && cmd.op == OP_BRANCH_SIGNED_BELOW && !sgn_lt |=>
    PC_O == 16'($past(PC_O) + PC_STEP) && !BUSY_O) else $error("branch not taken");
  a_ret_stack: assert property (start && cmd.op == OP_ROUTINE_EXIT |=>
    PC_O == $past(stack) && $stable(FLAGS_O)) else $error("return pc");
  a_ones_flags: assert property (start && cmd.op == OP_REGISTER_ALL_ONES |=>
    $stable(FLAGS_O) && result.value[7:0] == BYTE_ONES) else $error("all ones");

  c_long_skip: cover property (start && cmd.op == OP_EQUAL_SKIP && skip && cmd.next_long);
  c_frac_mul: cover property (start && cmd.op == OP_FRACTION_PRODUCT_SIGNED);
  c_refused: cover property (PSLVERR_O && PREADY_O && busy);
  c_irq_exit: cover property (start && cmd.op == OP_IRQ_EXIT);
endmodule
`default_nettype wire

// ==== exec_pkg.sv ====
// constants and types shared by the execute stage
package exec_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_ZPTR = 8'h10;
  localparam logic [7:0] OFS_STACK = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  // status flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_I = 7;
  // flag update masks
  localparam logic [7:0] M_ARITH = 8'h2F;
  localparam logic [7:0] M_LOGIC = 8'h0E;
  localparam logic [7:0] M_ONES = 8'h0F;
  localparam logic [7:0] M_WORD = 8'h1F;
  localparam logic [7:0] M_MUL = 8'h03;
  localparam logic [7:0] M_IRQ = 8'h80;
  // operand layout
  localparam int BYTE_MSB = 7;
  localparam int NIB_MSB = 3;
  localparam int WORD_MSB = 15;
  localparam int WK_W = 6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] INC_OVF = 8'h80;
  localparam logic [7:0] DEC_OVF = 8'h7F;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // program counter steps and reset value
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] CALL_STEP = 16'h0002;
  localparam logic [15:0] SKIP_SHORT = 16'h0002;
  localparam logic [15:0] SKIP_LONG = 16'h0003;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // cycle counts
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;

  typedef enum logic [5:0] {
    OP_SUM = 6'h00, OP_SUM_CARRY = 6'h01, OP_WORD_IMMEDIATE_SUM = 6'h02,
    OP_DIFFERENCE = 6'h03, OP_DIFFERENCE_WITH_BORROW = 6'h04,
    OP_WORD_IMMEDIATE_DIFFERENCE = 6'h05, OP_MASK = 6'h06, OP_MERGE = 6'h07,
    OP_EXCLUSIVE_MERGE = 6'h08, OP_ONES_INVERSE = 6'h09, OP_TWOS_INVERSE = 6'h0A,
    OP_BITS_FORCE_LOW = 6'h0B, OP_PLUS_ONE = 6'h0C, OP_MINUS_ONE = 6'h0D,
    OP_ZERO_MINUS_CHECK = 6'h0E, OP_REGISTER_ZEROING = 6'h0F,
    OP_REGISTER_ALL_ONES = 6'h10, OP_UNSIGNED_PRODUCT = 6'h11,
    OP_SIGNED_PRODUCT = 6'h12, OP_MIXED_SIGN_PRODUCT = 6'h13,
    OP_FRACTION_PRODUCT_UNSIGNED = 6'h14, OP_FRACTION_PRODUCT_SIGNED = 6'h15,
    OP_FRACTION_PRODUCT_MIXED = 6'h16, OP_RELATIVE_GOTO = 6'h17,
    OP_POINTER_GOTO = 6'h18, OP_ABSOLUTE_GOTO = 6'h19,
    OP_RELATIVE_ROUTINE_ENTRY = 6'h1A, OP_POINTER_ROUTINE_ENTRY = 6'h1B,
    OP_DIRECT_ROUTINE_ENTRY = 6'h1C, OP_ROUTINE_EXIT = 6'h1D, OP_IRQ_EXIT = 6'h1E,
    OP_EQUAL_SKIP = 6'h1F, OP_COMPARE_REGS = 6'h20, OP_COMPARE_REGS_BORROW = 6'h21,
    OP_REG_BIT_LOW_SKIP = 6'h22, OP_REG_BIT_HIGH_SKIP = 6'h23,
    OP_IO_BIT_LOW_SKIP = 6'h24, OP_IO_BIT_HIGH_SKIP = 6'h25,
    OP_BRANCH_FLAG_HIGH = 6'h26, OP_BRANCH_FLAG_LOW = 6'h27,
    OP_BRANCH_SIGNED_AT_LEAST = 6'h28, OP_BRANCH_SIGNED_BELOW = 6'h29
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } state_e;

  // command word, low bits of a write to the command register
  typedef struct packed {
    logic next_long;
    logic [2:0] bit_sel;
    logic [2:0] flag_sel;
    op_e op;
  } cmd_s;

  // result of the last instruction towards register file and stack
  typedef struct packed {
    logic push;
    logic pop;
    logic we_hi;
    logic we_lo;
    logic [15:0] value;
  } result_s;
endpackage

// ==== tb_cpu_alu_branch_execute.sv ====
// self-checking bench for the execute stage
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_alu_branch_execute import exec_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, err;
  logic [7:0] paddr, flags;
  logic [15:0] pc;
  logic [31:0] pwdata, prdata, rd;
  int checks = 0;
  int miscompares = 0;

  always #10 clk = ~clk;

  cpu_alu_branch_execute uut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PC_O(pc),
    .FLAGS_O(flags), .BUSY_O(busy));
  apb_drv drv (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drv.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdw(input logic [7:0] a);
    drv.xfer(1'b0, a, 32'h0, rd, err);
  endtask

  // waits until the remaining cycles of an instruction are over
  task automatic settle();
    #1;
    while (busy !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // x is {next_long, bit_sel, flag_sel}; pc starts at zero
  task automatic ex(input op_e op, input logic [6:0] x, input logic [15:0] a, b,
                    input logic [7:0] fi, input logic [15:0] ev, vm,
                    input logic [7:0] ef, input logic [15:0] ep, input logic [3:0] ec);
    wr(OFS_OPA, {16'h0, a});
    wr(OFS_OPB, {16'h0, b});
    wr(OFS_FLAGS, {24'h0, fi});
    wr(OFS_PC, 32'h0);
    wr(OFS_CMD, {19'h0, x, op});
    #1;
    check({31'h0, busy}, {31'h0, ec != CYC_ONE});
    settle();
    check({8'h0, pc, flags}, {8'h0, ep, ef});
    rdw(OFS_RESULT);
    check({16'h0, rd[15:0] & vm}, {16'h0, ev & vm});
    rdw(OFS_STAT);
    check({28'h0, rd[4:1]}, {28'h0, ec});
  endtask

  task automatic t_reset();
    check({7'h0, busy, pc, flags}, 32'h0);
    rdw(OFS_RESULT);
    check(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_arith();
    ex(OP_SUM, 7'h0, 16'hF, 16'h1, 8'h0, 16'h10, 16'hFF, 8'h20, 16'h1, 4'h1);
    ex(OP_SUM, 7'h0, 16'h80, 16'h80, 8'h0, 16'h0, 16'hFF, 8'h0B, 16'h1, 4'h1);
    ex(OP_SUM_CARRY, 7'h0, 16'hFF, 16'h0, 8'h1, 16'h0, 16'hFF, 8'h23, 16'h1, 4'h1);
    ex(OP_DIFFERENCE, 7'h0, 16'h0, 16'h1, 8'h0, 16'hFF, 16'hFF, 8'h25, 16'h1, 4'h1);
    ex(OP_DIFFERENCE_WITH_BORROW, 7'h0, 16'h10, 16'h0, 8'h1, 16'hF, 16'hFF, 8'h20, 16'h1, 4'h1);
    ex(OP_COMPARE_REGS, 7'h0, 16'h5, 16'h5, 8'h1, 16'h0, 16'h0, 8'h2, 16'h1, 4'h1);
    ex(OP_COMPARE_REGS_BORROW, 7'h0, 16'h5, 16'h5, 8'h0, 16'h0, 16'h0, 8'h0, 16'h1, 4'h1);
    $display("arith test done");
  endtask

  task automatic t_logic();
    ex(OP_MASK, 7'h0, 16'hF0, 16'hF, 8'h21, 16'h0, 16'hFF, 8'h23, 16'h1, 4'h1);
    ex(OP_ONES_INVERSE, 7'h0, 16'h55, 16'h0, 8'h0, 16'hAA, 16'hFF, 8'h5, 16'h1, 4'h1);
    ex(OP_TWOS_INVERSE, 7'h0, 16'h1, 16'h0, 8'h0, 16'hFF, 16'hFF, 8'h25, 16'h1, 4'h1);
    ex(OP_BITS_FORCE_LOW, 7'h0, 16'hFF, 16'hF, 8'h0, 16'hF0, 16'hFF, 8'h4, 16'h1, 4'h1);
    ex(OP_MINUS_ONE, 7'h0, 16'h80, 16'h0, 8'h1, 16'h7F, 16'hFF, 8'h9, 16'h1, 4'h1);
    ex(OP_REGISTER_ALL_ONES, 7'h0, 16'h0, 16'h0, 8'h2F, 16'hFF, 16'hFF, 8'h2F, 16'h1, 4'h1);
    ex(OP_MERGE, 7'h0, 16'hF, 16'h80, 8'h21, 16'h8F, 16'hFF, 8'h25, 16'h1, 4'h1);
    ex(OP_EXCLUSIVE_MERGE, 7'h0, 16'hAA, 16'hAA, 8'h8, 16'h0, 16'hFF, 8'h2, 16'h1, 4'h1);
    ex(OP_PLUS_ONE, 7'h0, 16'h7F, 16'h0, 8'h1, 16'h80, 16'hFF, 8'hD, 16'h1, 4'h1);
    ex(OP_ZERO_MINUS_CHECK, 7'h0, 16'h80, 16'h0, 8'h0, 16'h80, 16'hFF, 8'h4, 16'h1, 4'h1);
    ex(OP_REGISTER_ZEROING, 7'h0, 16'h5A, 16'h0, 8'h4, 16'h0, 16'hFF, 8'h2, 16'h1, 4'h1);
    $display("logic test done");
  endtask

  task automatic t_wide();
    ex(OP_WORD_IMMEDIATE_SUM, 7'h0, 16'hFF, 16'h1, 8'h1F, 16'h100, 16'hFFFF, 8'h0, 16'h1, 4'h2);
    ex(OP_WORD_IMMEDIATE_DIFFERENCE, 7'h0, 16'h0, 16'h1, 8'h0, 16'hFFFF, 16'hFFFF, 8'h15, 16'h1, 4'h2);
    ex(OP_UNSIGNED_PRODUCT, 7'h0, 16'hFF, 16'hFF, 8'h0, 16'hFE01, 16'hFFFF, 8'h1, 16'h1, 4'h2);
    ex(OP_FRACTION_PRODUCT_UNSIGNED, 7'h0, 16'h80, 16'h80, 8'h0, 16'h8000, 16'hFFFF, 8'h0, 16'h1, 4'h2);
    ex(OP_SIGNED_PRODUCT, 7'h0, 16'hFF, 16'h2, 8'h0, 16'hFFFE, 16'hFFFF, 8'h1, 16'h1, 4'h2);
    ex(OP_MIXED_SIGN_PRODUCT, 7'h0, 16'hFF, 16'hFF, 8'h0, 16'hFF01, 16'hFFFF, 8'h1, 16'h1, 4'h2);
    ex(OP_FRACTION_PRODUCT_SIGNED, 7'h0, 16'hC0, 16'h40, 8'h0, 16'hE000, 16'hFFFF, 8'h1, 16'h1, 4'h2);
    ex(OP_FRACTION_PRODUCT_MIXED, 7'h0, 16'hFF, 16'h80, 8'h0, 16'hFF00, 16'hFFFF, 8'h1, 16'h1, 4'h2);
    $display("wide test done");
  endtask

  task automatic t_flow();
    ex(OP_BRANCH_SIGNED_BELOW, 7'h0, 16'h0, 16'h5, 8'h4, 16'h0, 16'h0, 8'h4, 16'h6, 4'h2);
    ex(OP_BRANCH_SIGNED_AT_LEAST, 7'h0, 16'h0, 16'h5, 8'h4, 16'h0, 16'h0, 8'h4, 16'h1, 4'h1);
    ex(OP_BRANCH_FLAG_HIGH, 7'h5, 16'h0, 16'hFFFE, 8'h20, 16'h0, 16'h0, 8'h20, 16'hFFFF, 4'h2);
    ex(OP_BRANCH_FLAG_LOW, 7'h0, 16'h0, 16'h3, 8'h0, 16'h0, 16'h0, 8'h0, 16'h4, 4'h2);
    ex(OP_EQUAL_SKIP, 7'h40, 16'h33, 16'h33, 8'h0, 16'h0, 16'h0, 8'h0, 16'h3, 4'h3);
    ex(OP_REG_BIT_HIGH_SKIP, 7'h38, 16'h80, 16'h0, 8'h0, 16'h0, 16'h0, 8'h0, 16'h2, 4'h2);
    ex(OP_IO_BIT_LOW_SKIP, 7'h0, 16'hFE, 16'h0, 8'h0, 16'h0, 16'h0, 8'h0, 16'h2, 4'h2);
    ex(OP_REG_BIT_LOW_SKIP, 7'h8, 16'h2, 16'h0, 8'h0, 16'h0, 16'h0, 8'h0, 16'h1, 4'h1);
    ex(OP_IO_BIT_HIGH_SKIP, 7'h40, 16'h1, 16'h0, 8'h0, 16'h0, 16'h0, 8'h0, 16'h3, 4'h3);
    ex(OP_RELATIVE_GOTO, 7'h0, 16'h0, 16'h4, 8'h0, 16'h0, 16'h0, 8'h0, 16'h5, 4'h2);
    ex(OP_RELATIVE_ROUTINE_ENTRY, 7'h0, 16'h0, 16'h4, 8'h0, 16'h1, 16'hFFFF, 8'h0, 16'h5, 4'h3);
    ex(OP_DIRECT_ROUTINE_ENTRY, 7'h0, 16'h0, 16'h400, 8'h0, 16'h2, 16'hFFFF, 8'h0, 16'h400, 4'h4);
    ex(OP_ABSOLUTE_GOTO, 7'h0, 16'h0, 16'h200, 8'h0, 16'h0, 16'h0, 8'h0, 16'h200, 4'h3);
    wr(OFS_ZPTR, 32'h300);
    ex(OP_POINTER_GOTO, 7'h0, 16'h0, 16'h0, 8'h0, 16'h0, 16'h0, 8'h0, 16'h300, 4'h2);
    ex(OP_POINTER_ROUTINE_ENTRY, 7'h0, 16'h0, 16'h0, 8'h0, 16'h1, 16'hFFFF, 8'h0, 16'h300, 4'h3);
    $display("flow test done");
  endtask

  task automatic t_refuse();
    wr(OFS_STACK, 32'h1234);
    ex(OP_ROUTINE_EXIT, 7'h0, 16'h0, 16'h9, 8'h0, 16'h0, 16'h0, 8'h0, 16'h1234, 4'h4);
    ex(OP_IRQ_EXIT, 7'h0, 16'h0, 16'h0, 8'h0, 16'h0, 16'h0, 8'h80, 16'h1234, 4'h4);
    wr(OFS_CMD, {26'h0, OP_ROUTINE_EXIT});
    wr(OFS_CMD, {26'h0, OP_RELATIVE_GOTO});
    check({31'h0, err}, 32'h1);
    settle();
    check({16'h0, pc}, 32'h1234);
    rdw(8'h24);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("refuse test done");
  endtask

  initial
  begin
    #100_000;
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_arith();
    t_logic();
    t_wide();
    t_flow();
    t_refuse();
    conclude();
  end
endmodule
`default_nettype wire
